// ===== src/slsr_defs.svh
/*
   Constants of the stack light SPI register slave: frame layout, register
   offsets, reset values and limits.
   Assumes inclusion by bare name from the package, whose macros the slave module uses.
*/
`ifndef SLSR_DEFS_SVH
`define SLSR_DEFS_SVH

// frame layout, most significant bit first
`define SLSR_FRAME_BITS 32
`define SLSR_HEAD_BITS 8
`define SLSR_RW_BIT 31
`define SLSR_ADDR_HI 30
`define SLSR_ADDR_LO 24
`define SLSR_DATA_HI 23
`define SLSR_DATA_LO 0
`define SLSR_CNT_HEAD_END 5'h07
`define SLSR_CNT_FRAME_END 5'h1F

// register offsets
`define SLSR_OFF_OPERATING_MODE 7'h01
`define SLSR_OFF_LIGHT_PATTERN 7'h02
`define SLSR_OFF_RGB_COLOUR 7'h03
`define SLSR_OFF_BRIGHTNESS_LEVEL 7'h04
`define SLSR_OFF_BLINK_PERIOD 7'h05
`define SLSR_OFF_PATTERN_ARGUMENT 7'h06
`define SLSR_OFF_TEMPERATURE_RANGE_LOW 7'h07
`define SLSR_OFF_TEMPERATURE_RANGE_HIGH 7'h08
`define SLSR_OFF_LEVEL_RANGE_LOW 7'h09
`define SLSR_OFF_LEVEL_RANGE_HIGH 7'h0A
`define SLSR_OFF_AMBIENT_TEMPERATURE 7'h0B
`define SLSR_OFF_AMBIENT_HUMIDITY 7'h0C

// reset values
`define SLSR_RST_OPERATING_MODE 24'h000000
`define SLSR_RST_LIGHT_PATTERN 24'h000000
`define SLSR_RST_RGB_COLOUR 24'hFFFFFF
`define SLSR_RST_BRIGHTNESS_LEVEL 24'h000001
`define SLSR_RST_BLINK_PERIOD 24'h000014
`define SLSR_RST_PATTERN_ARGUMENT 24'h000014
`define SLSR_RST_TEMPERATURE_RANGE_LOW 24'h00000F
`define SLSR_RST_TEMPERATURE_RANGE_HIGH 24'h00001E
`define SLSR_RST_LEVEL_RANGE_LOW 24'h000000
`define SLSR_RST_LEVEL_RANGE_HIGH 24'h000064

// colour field positions
`define SLSR_RED_HI 23
`define SLSR_RED_LO 16
`define SLSR_GREEN_HI 15
`define SLSR_GREEN_LO 8
`define SLSR_BLUE_HI 7
`define SLSR_BLUE_LO 0

// brightness limit
`define SLSR_BRIGHT_MAX 127

`endif

// ===== src/slsr_pkg.sv
/*
   Types of the stack light SPI register slave: modes, patterns, frame
   states and the structs that carry the register set to the renderer.
   Assumes slsr_defs.svh is reachable on the include path.
*/
package slsr_pkg;
`include "slsr_defs.svh"

   typedef enum logic [23:0] {
      SLSR_MODE_DEMO = 24'h000000,
      SLSR_MODE_TEMPERATURE = 24'h000001,
      SLSR_MODE_HUMIDITY = 24'h000002,
      SLSR_MODE_STACK = 24'h000003
   } slsr_mode_t;

   typedef enum logic [23:0] {
      SLSR_PAT_OFF = 24'h000000,
      SLSR_PAT_ALL_ON = 24'h000001,
      SLSR_PAT_BLINK = 24'h000002,
      SLSR_PAT_STACK = 24'h000003,
      SLSR_PAT_TEMPERATURE = 24'h000004,
      SLSR_PAT_RUN = 24'h000005,
      SLSR_PAT_LEVEL = 24'h000006
   } slsr_pattern_t;

   typedef enum logic [3:0] {
      SLSR_ST_IDLE = 4'b0001,
      SLSR_ST_HEAD = 4'b0010,
      SLSR_ST_BODY = 4'b0100,
      SLSR_ST_DONE = 4'b1000
   } slsr_state_t;

   typedef struct packed {
      logic [23:0] operating_mode;
      logic [23:0] light_pattern;
      logic [23:0] rgb_colour;
      logic [23:0] brightness_level;
      logic [23:0] blink_period;
      logic [23:0] pattern_argument;
      logic [23:0] temperature_range_low;
      logic [23:0] temperature_range_high;
      logic [23:0] level_range_low;
      logic [23:0] level_range_high;
   } slsr_regs_t;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } slsr_rgb_t;

   typedef struct packed {
      logic show_count;
      logic show_segment;
      logic show_scaled;
      logic [23:0] led_count;
      logic [23:0] segment;
      logic [23:0] scale_offset;
      logic [23:0] scale_span;
   } slsr_view_t;
endpackage

// ===== src/slsr_spi_regs.sv
/*
   SPI slave register bank of a multi-segment RGB stack light controller:
   pin synchronisers, 32-bit frame engine in clock mode one, register set,
   read multiplexer and the pattern argument decode handed to the renderer.
   Assumes the host is the SPI master, SCLK runs at most mclk/8, and the
   ambient sensor values arrive from logic on mclk.
*/
module slsr_spi_regs
   import slsr_pkg::*;
#(
   parameter int FRAME_BITS = `SLSR_FRAME_BITS,
   parameter int BRIGHT_MAX = `SLSR_BRIGHT_MAX
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic [23:0] ambient_temperature,
   input wire logic [23:0] ambient_humidity,
   output slsr_regs_t regs,
   output slsr_rgb_t colour,
   output slsr_view_t view,
   output logic write_strobe
);

   if (FRAME_BITS != 32) begin : g_bad_frame
      $error("frame engine serves only 32-bit frames");
   end
   if (BRIGHT_MAX < 1 || BRIGHT_MAX > 255) begin : g_bad_bright
      $error("brightness limit out of range");
   end

   localparam logic [23:0] BRIGHT_LIMIT = 24'(BRIGHT_MAX);
   localparam logic [2:0] PIN_IDLE = 3'h2;

   function automatic logic slsr_writable(input logic [6:0] addr);
      return addr >= `SLSR_OFF_OPERATING_MODE && addr <= `SLSR_OFF_LEVEL_RANGE_HIGH;
   endfunction

   function automatic logic [23:0] slsr_read(input logic [6:0] addr, input slsr_regs_t r,
                                             input logic [23:0] temp,
                                             input logic [23:0] hum);
      logic [23:0] v;
      v = 24'h000000;
      unique case (addr)
         `SLSR_OFF_OPERATING_MODE: v = r.operating_mode;
         `SLSR_OFF_LIGHT_PATTERN: v = r.light_pattern;
         `SLSR_OFF_RGB_COLOUR: v = r.rgb_colour;
         `SLSR_OFF_BRIGHTNESS_LEVEL: v = r.brightness_level;
         `SLSR_OFF_BLINK_PERIOD: v = r.blink_period;
         `SLSR_OFF_PATTERN_ARGUMENT: v = r.pattern_argument;
         `SLSR_OFF_TEMPERATURE_RANGE_LOW: v = r.temperature_range_low;
         `SLSR_OFF_TEMPERATURE_RANGE_HIGH: v = r.temperature_range_high;
         `SLSR_OFF_LEVEL_RANGE_LOW: v = r.level_range_low;
         `SLSR_OFF_LEVEL_RANGE_HIGH: v = r.level_range_high;
         `SLSR_OFF_AMBIENT_TEMPERATURE: v = temp;
         `SLSR_OFF_AMBIENT_HUMIDITY: v = hum;
         default: v = 24'h000000;
      endcase
      return v;
   endfunction

   // two-stage synchronisers: bit 2 sclk, bit 1 cs_n, bit 0 mosi
   logic [2:0] pin_raw;
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   assign pin_raw = {spi_sclk, spi_cs_n, spi_mosi};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            pin_meta[i] <= PIN_IDLE[i];
            pin_sync[i] <= PIN_IDLE[i];
         end else begin
            pin_meta[i] <= pin_raw[i];
            pin_sync[i] <= pin_meta[i];
         end
      end
   end

   logic sclk_prev;
   logic cs_n_prev;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclk_prev <= 1'b0;
         cs_n_prev <= 1'b1;
      end else begin
         sclk_prev <= pin_sync[2];
         cs_n_prev <= pin_sync[1];
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_release;
   logic selected;
   assign sclk_rise = pin_sync[2] & ~sclk_prev;
   assign sclk_fall = ~pin_sync[2] & sclk_prev;
   assign cs_release = pin_sync[1] & ~cs_n_prev;
   assign selected = ~pin_sync[1];

   slsr_state_t state;
   logic [4:0] bit_cnt;
   logic [31:0] rx_shift;
   logic [31:0] next_frame;
   logic [23:0] tx_shift;
   logic cmd_rw;
   logic [6:0] cmd_addr;
   logic sample;
   logic head_end;
   logic last_bit;

   assign sample = sclk_fall & selected & (state == SLSR_ST_HEAD || state == SLSR_ST_BODY);
   assign next_frame = {rx_shift[30:0], pin_sync[0]};
   assign head_end = sample && state == SLSR_ST_HEAD && bit_cnt == `SLSR_CNT_HEAD_END;
   assign last_bit = sample && state == SLSR_ST_BODY && bit_cnt == `SLSR_CNT_FRAME_END;

   // frame position; deselect drops whatever was partly received
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= SLSR_ST_IDLE;
      end else if (!selected) begin
         state <= SLSR_ST_IDLE;
      end else begin
         unique case (state)
            SLSR_ST_IDLE: state <= SLSR_ST_HEAD;
            SLSR_ST_HEAD: if (head_end) begin
               state <= SLSR_ST_BODY;
            end
            SLSR_ST_BODY: if (last_bit) begin
               state <= SLSR_ST_DONE;
            end
            SLSR_ST_DONE: state <= SLSR_ST_DONE;
            default: state <= SLSR_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= 5'h00;
         rx_shift <= 32'h00000000;
      end else if (!selected) begin
         bit_cnt <= 5'h00;
      end else if (sample) begin
         bit_cnt <= bit_cnt + 5'h01;
         rx_shift <= next_frame;
      end
   end

   // header byte: direction and address, read value snapshot
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_rw <= 1'b0;
         cmd_addr <= 7'h00;
      end else if (head_end) begin
         cmd_rw <= next_frame[7];
         cmd_addr <= next_frame[6:0];
      end
   end

   // outgoing bits change on the rising edge, the master samples on falling
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_shift <= 24'h000000;
         spi_miso <= 1'b0;
      end else if (state == SLSR_ST_IDLE || !selected) begin
         tx_shift <= 24'h000000;
         spi_miso <= 1'b0;
      end else if (head_end) begin
         if (next_frame[7]) begin
            tx_shift <= slsr_read(next_frame[6:0], regs, ambient_temperature,
                                  ambient_humidity);
         end else begin
            tx_shift <= 24'h000000;
         end
      end else if (sclk_rise && state == SLSR_ST_BODY) begin
         spi_miso <= tx_shift[23];
         tx_shift <= {tx_shift[22:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_oe <= selected;
      end
   end

   // register set; writes land only once the fourth byte is complete
   logic do_write;
   logic [23:0] wdata;
   assign do_write = last_bit && !cmd_rw && slsr_writable(cmd_addr);
   assign wdata = next_frame[`SLSR_DATA_HI:`SLSR_DATA_LO];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         regs.operating_mode <= `SLSR_RST_OPERATING_MODE;
         regs.light_pattern <= `SLSR_RST_LIGHT_PATTERN;
         regs.rgb_colour <= `SLSR_RST_RGB_COLOUR;
         regs.brightness_level <= `SLSR_RST_BRIGHTNESS_LEVEL;
         regs.blink_period <= `SLSR_RST_BLINK_PERIOD;
         regs.pattern_argument <= `SLSR_RST_PATTERN_ARGUMENT;
         regs.temperature_range_low <= `SLSR_RST_TEMPERATURE_RANGE_LOW;
         regs.temperature_range_high <= `SLSR_RST_TEMPERATURE_RANGE_HIGH;
         regs.level_range_low <= `SLSR_RST_LEVEL_RANGE_LOW;
         regs.level_range_high <= `SLSR_RST_LEVEL_RANGE_HIGH;
      end else if (do_write) begin
         unique case (cmd_addr)
            `SLSR_OFF_OPERATING_MODE: regs.operating_mode <= wdata;
            `SLSR_OFF_LIGHT_PATTERN: regs.light_pattern <= wdata;
            `SLSR_OFF_RGB_COLOUR: regs.rgb_colour <= wdata;
            `SLSR_OFF_BRIGHTNESS_LEVEL:
               regs.brightness_level <= (wdata > BRIGHT_LIMIT) ? BRIGHT_LIMIT : wdata;
            `SLSR_OFF_BLINK_PERIOD: regs.blink_period <= wdata;
            `SLSR_OFF_PATTERN_ARGUMENT: regs.pattern_argument <= wdata;
            `SLSR_OFF_TEMPERATURE_RANGE_LOW: regs.temperature_range_low <= wdata;
            `SLSR_OFF_TEMPERATURE_RANGE_HIGH: regs.temperature_range_high <= wdata;
            `SLSR_OFF_LEVEL_RANGE_LOW: regs.level_range_low <= wdata;
            `SLSR_OFF_LEVEL_RANGE_HIGH: regs.level_range_high <= wdata;
            default: regs.operating_mode <= regs.operating_mode;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         write_strobe <= 1'b0;
      end else begin
         write_strobe <= do_write;
      end
   end

   assign colour = slsr_rgb_t'(regs.rgb_colour);

   // pattern argument decode for the renderer
   logic [23:0] rng_lo;
   logic [23:0] rng_hi;
   logic [23:0] clamped;
   logic is_count;
   logic is_scaled;
   always_comb begin
      is_count = regs.light_pattern == SLSR_PAT_ALL_ON || regs.light_pattern == SLSR_PAT_BLINK ||
                 regs.light_pattern == SLSR_PAT_RUN;
      is_scaled = regs.light_pattern == SLSR_PAT_TEMPERATURE ||
                  regs.light_pattern == SLSR_PAT_LEVEL;
      if (regs.light_pattern == SLSR_PAT_TEMPERATURE) begin
         rng_lo = regs.temperature_range_low;
         rng_hi = regs.temperature_range_high;
      end else begin
         rng_lo = regs.level_range_low;
         rng_hi = regs.level_range_high;
      end
      if (regs.pattern_argument < rng_lo) begin
         clamped = rng_lo;
      end else if (regs.pattern_argument > rng_hi) begin
         clamped = rng_hi;
      end else begin
         clamped = regs.pattern_argument;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         view <= '0;
      end else begin
         view.show_count <= is_count;
         view.show_segment <= regs.light_pattern == SLSR_PAT_STACK;
         view.show_scaled <= is_scaled && rng_hi >= rng_lo;
         view.led_count <= is_count ? regs.pattern_argument : 24'h000000;
         view.segment <= (regs.light_pattern == SLSR_PAT_STACK) ? regs.pattern_argument :
                         24'h000000;
         view.scale_offset <= (is_scaled && rng_hi >= rng_lo) ? clamped - rng_lo :
                              24'h000000;
         view.scale_span <= (is_scaled && rng_hi >= rng_lo) ? rng_hi - rng_lo :
                            24'h000000;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_last_write;
      last_bit && !cmd_rw;
   endsequence

   sequence s_read_head;
      head_end && next_frame[7];
   endsequence

   property p_frame_len;
      last_bit |=> state == SLSR_ST_DONE && !sample;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame did not close at bit 32");

   property p_cs_release;
      cs_release |-> ##1 (bit_cnt == 5'h00 && state == SLSR_ST_IDLE) ##1 !spi_miso;
   endproperty
   a_cs_release: assert property (p_cs_release) else $error("deselect kept frame state");

   property p_hiz;
      !selected |=> !spi_miso_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output enabled while deselected");

   property p_read_load;
      s_read_head |=> cmd_rw && cmd_addr == $past(next_frame[6:0]) &&
         tx_shift == slsr_read($past(next_frame[6:0]), $past(regs),
                               $past(ambient_temperature), $past(ambient_humidity));
   endproperty
   a_read_load: assert property (p_read_load) else $error("read value not loaded");

   property p_shift_out;
      sclk_rise && selected && state == SLSR_ST_BODY && !head_end |=>
         spi_miso == $past(tx_shift[23]);
   endproperty
   a_shift_out: assert property (p_shift_out) else $error("output bit out of order");

   property p_mode_write;
      s_last_write ##0 cmd_addr == `SLSR_OFF_OPERATING_MODE |=>
         regs.operating_mode == $past(wdata) ##1 write_strobe == 1'b0 || do_write;
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");

   property p_read_no_write;
      last_bit && cmd_rw |=> $stable(regs) && !write_strobe;
   endproperty
   a_read_no_write: assert property (p_read_no_write) else $error("read changed a register");

   property p_ro_regs;
      s_last_write ##0 !slsr_writable(cmd_addr) |=> $stable(regs);
   endproperty
   a_ro_regs: assert property (p_ro_regs) else $error("read-only address was written");

   property p_bright_cap;
      regs.brightness_level <= BRIGHT_LIMIT;
   endproperty
   a_bright_cap: assert property (p_bright_cap) else $error("brightness above limit");

   property p_head_quiet;
      state == SLSR_ST_HEAD |-> !spi_miso;
   endproperty
   a_head_quiet: assert property (p_head_quiet) else $error("output active in header byte");

   property p_temp_read;
      s_read_head ##0 next_frame[6:0] == `SLSR_OFF_AMBIENT_TEMPERATURE |=>
         tx_shift == $past(ambient_temperature);
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("temperature read value wrong");

   property p_hum_read;
      s_read_head ##0 next_frame[6:0] == `SLSR_OFF_AMBIENT_HUMIDITY |=>
         tx_shift == $past(ambient_humidity);
   endproperty
   a_hum_read: assert property (p_hum_read) else $error("humidity read value wrong");

endmodule

// ===== sim/slsr_host_model.sv
/*
   Host side of the stack light register link: an SPI master in clock
   mode one that shifts whole, cut-short or over-long frames and collects the answer.
   Assumes mclk is the device clock and that the bench calls xfer between frames.
*/
module slsr_host_model (
   input wire logic mclk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   output logic oe_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   // each sclk phase lasts six device clocks
   localparam int HALF = 6;
   logic drive_bit = 1'b0;
   logic busy = 1'b0;
   logic idle_pat = 1'b0;
   // data line carries no stale value between frames
   assign spi_mosi = busy ? drive_bit : idle_pat;
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      oe_ok = 1'b1;
   end
   always @(negedge mclk) begin
      idle_pat <= ~idle_pat;
   end
   task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
      rx = '0;
      oe_ok = 1'b1;
      @(negedge mclk);
      spi_cs_n = 1'b0;
      busy = 1'b1;
      repeat (HALF) @(negedge mclk);
      for (int i = 0; i < nbits; i++) begin
         spi_sclk = 1'b1;
         drive_bit = (i < 32) ? tx[31 - i] : 1'b0;
         repeat (HALF) @(negedge mclk);
         // a released line reads inverted, so a stale bit cannot slip through
         rx = {rx[30:0], spi_miso_oe ? spi_miso : ~spi_miso};
         oe_ok = oe_ok & spi_miso_oe;
         spi_sclk = 1'b0;
         repeat (HALF) @(negedge mclk);
      end
      spi_cs_n = 1'b1;
      busy = 1'b0;
      repeat (HALF) @(negedge mclk);
   endtask
endmodule

// ===== sim/stack_light_spi_register_slave_tb_top.sv
/*
   Self-checking bench of the stack light register slave: a register model
   in integers is compared with reads, the register outputs and the decode.
   Assumes the host model drives the pins and the design package is compiled.
*/
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t ns: got %h expected %h", $time, (g), (e)); end end

module stack_light_spi_register_slave_tb_top
   import slsr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, write_strobe, oe_ok;
   logic [23:0] ambient_temperature = 24'h000000;
   logic [23:0] ambient_humidity = 24'h000000;
   logic [15:0] lfsr_state = 16'hCED0;
   logic [31:0] rx;
   slsr_regs_t regs;
   slsr_rgb_t colour;
   slsr_view_t view;
   int err_count = 0;
   int compares = 0;
   int strobes = 0;
   int strobes_exp = 0;
   int mdl [0:127];

   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      if (write_strobe === 1'b1) strobes <= strobes + 1;
   end

   slsr_spi_regs u_slsr_spi_regs (.mclk(mclk), .resetn(resetn), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .ambient_temperature(ambient_temperature),
      .ambient_humidity(ambient_humidity), .regs(regs), .colour(colour), .view(view),
      .write_strobe(write_strobe));
   slsr_host_model u_slsr_host_model (.mclk(mclk), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .oe_ok(oe_ok));

   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function logic [23:0] rnd24();
      repeat (24) lfsr_state = lfsr_next(lfsr_state);
      return {lfsr_state[7:0], lfsr_state};
   endfunction
   function automatic int mdl_read(int a);
      if (a == 11) return ambient_temperature;
      if (a == 12) return ambient_humidity;
      if (a >= 1 && a <= 10) return mdl[a];
      return 0;
   endfunction
   task mdl_reset();
      mdl = '{default: 0};
      mdl[3] = 24'hFFFFFF;
      mdl[4] = 1;
      mdl[5] = 24'h000014;
      mdl[6] = 24'h000014;
      mdl[7] = 24'h00000F;
      mdl[8] = 24'h00001E;
      mdl[10] = 24'h000064;
   endtask
   task automatic wr(int a, int d);
      logic [31:0] r;
      u_slsr_host_model.xfer({1'b0, 7'(a), 24'(d)}, 32, r);
      if (a >= 1 && a <= 10) begin
         mdl[a] = (a == 4 && d > 127) ? 127 : d;
         strobes_exp++;
      end
   endtask
   task automatic rd_chk(int a);
      logic [31:0] r;
      u_slsr_host_model.xfer({1'b1, 7'(a), rnd24()}, 32, r);
      `CHK(r[23:0], 24'(mdl_read(a)))
      `CHK(oe_ok, 1'b1)
   endtask
   task automatic check_all();
      int p, arg, lo, hi, c;
      logic [2:0] shows;
      for (int k = 1; k <= 10; k++) begin
         `CHK(regs[263 - 24 * k -: 24], 24'(mdl[k]))
      end
      `CHK(colour, 24'(mdl[3]))
      `CHK(strobes, strobes_exp)
      `CHK({spi_miso_oe, spi_miso}, 2'b00)
      p = mdl[2];
      arg = mdl[6];
      lo = (p == 4) ? mdl[7] : mdl[9];
      hi = (p == 4) ? mdl[8] : mdl[10];
      shows = {p == 1 || p == 2 || p == 5, p == 3, (p == 4 || p == 6) && hi >= lo};
      `CHK({view.show_count, view.show_segment, view.show_scaled}, shows)
      if (shows[2]) `CHK(view.led_count, 24'(arg))
      if (shows[1]) `CHK(view.segment, 24'(arg))
      if (shows[0]) begin
         c = (arg < lo) ? lo : (arg > hi) ? hi : arg;
         `CHK(view.scale_offset, 24'(c - lo))
         `CHK(view.scale_span, 24'(hi - lo))
      end
   endtask
   task complete_run();
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (99000) @(posedge mclk);
      err_count++;
      complete_run();
   end

   initial begin
      int bv [4] = '{127, 128, 0, 24'hFFFFFF};
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      mdl_reset();
      ambient_temperature = rnd24();
      ambient_humidity = rnd24();
      repeat (2) @(negedge mclk);
      check_all();
      for (int a = 0; a < 16; a++) rd_chk(a);
      rd_chk(127);
      for (int n = 0; n < 2; n++) begin
         for (int a = 0; a < 14; a++) begin
            wr(a, rnd24());
            rd_chk(a);
         end
         wr(127, rnd24());
         check_all();
      end
      foreach (bv[i]) begin
         wr(4, bv[i]);
         rd_chk(4);
      end
      for (int p = 0; p < 7; p++) begin
         wr(1, p % 4);
         for (int a = 6; a <= 10; a++) wr(a, rnd24() & 24'h0000FF);
         wr(2, p);
         ambient_temperature = rnd24();
         ambient_humidity = rnd24();
         rd_chk(1);
         rd_chk(11);
         rd_chk(12);
         check_all();
      end
      // fixed ranges so that both scaled decodes and the clamp are reached
      wr(7, 24'h000000);
      wr(8, 24'h000064);
      wr(2, 4);
      wr(6, 24'h000014);
      check_all();
      wr(6, 24'h000070);
      check_all();
      wr(9, 24'h000050);
      wr(10, 24'h000010);
      wr(2, 6);
      check_all();
      wr(10, 24'h000060);
      check_all();
      u_slsr_host_model.xfer({1'b0, 7'h06, 24'h00ABCD}, 12, rx);
      check_all();
      rd_chk(6);
      u_slsr_host_model.xfer({1'b0, 7'h05, 24'h000321}, 40, rx);
      mdl[5] = 24'h000321;
      strobes_exp++;
      rd_chk(5);
      resetn = 1'b0;
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      mdl_reset();
      repeat (2) @(negedge mclk);
      check_all();
      complete_run();
   end
endmodule
